// [src/umic_ctrl.sv]
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// ==========================================================
// Modem control, modem status and interrupt enable block
// Operation
// [R1] INTERRUPT_ENABLE bit0 gates received-data interrupt
// [R2] INTERRUPT_ENABLE bit1 gates transmit-empty interrupt
// [R3] INTERRUPT_ENABLE bit2 gates line-status interrupt
// [R4] INTERRUPT_ENABLE bit3 gates modem-status interrupt
// [R5] INTERRUPT_ENABLE upper four bits read zero
// [R6] All enables zero inhibit identification and irq
// [R7] MODEM_CONTROL bit0 drives terminal-ready pin inverted
// [R8] MODEM_CONTROL bit1 drives request-to-send pin inverted
// [R9] MODEM_CONTROL bits2,3 drive auxiliary pins inverted
// [R10] Loopback marks tx pin, loops serial data
// [R11] Loopback routes control outputs to modem inputs
// [R12] Loopback modem interrupts come from MODEM_CONTROL bits
// [R13] Software may write line/modem status ones
// [R14] Software reprograms before clearing loopback
// [R15] MODEM_CONTROL bits 5 to 7 read zero
// [R16] Change flags clear on status read
// [R17] Bits 0,1,3 flag cts/dsr/carrier changes
// [R18] Bit 2 flags ring trailing edge only
// [R19] Any change flag requests modem interrupt
// [R20] Status bits 4-7 complement input pins
// [R21] Loopback status bits 4-7 mirror MODEM_CONTROL
// [R22] Priority: line, data, empty, modem
// [R23] Line bits 1-4 errors raise line interrupt
// [R24] Inputs synchronised before edge detection
// [R25] Reset clears INTERRUPT_ENABLE and MODEM_CONTROL
module umic_ctrl
    import umic_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cts_n_in,
    input  wire logic        dsr_n_in,
    input  wire logic        ring_n_in,
    input  wire logic        carrier_detect_in_n,
    input  wire logic        serial_rx_pin,
    input  wire logic        tx_shift_out,
    input  wire logic        rx_data_ready,
    input  wire logic        tx_holding_empty,
    input  wire logic [3:0]  line_err_set,
    output logic             rx_shift_in,
    output logic             serial_tx_pin,
    output logic             term_ready_n,
    output logic             req_to_send_n,
    output logic             aux_user_output_a_n,
    output logic             aux_user_output_b_n,
    output logic             irq_out
);
    // ==========================================================
    // Registers
    logic [3:0] ier_reg;
    logic [4:0] mcr_reg;
    logic [3:0] msr_flags_reg;
    logic [3:0] mdm_prev_reg;
    logic [5:0] lsr_reg;
    logic [2:0] iir_reg;
    logic       prime_reg;
    logic [3:0] msr_flags_next;
    logic [3:0] mdm_raw;
    logic [3:0] mdm_sync;
    logic [5:0] lsr_next;

    // Bus decode
    wire        acc      = psel && penable && ce;
    wire        wr       = acc && pwrite;
    wire        rd       = acc && !pwrite;
    wire        hit_ier  = (paddr == UMIC_OFF_IER);
    wire        hit_mcr  = (paddr == UMIC_OFF_MCR);
    wire        hit_msr  = (paddr == UMIC_OFF_MSR);
    wire        hit_lsr  = (paddr == UMIC_OFF_LSR);
    wire        hit_iir  = (paddr == UMIC_OFF_IIR);
    wire        mapped   = hit_ier | hit_mcr | hit_msr | hit_lsr | hit_iir;
    wire        loop     = mcr_reg[UMIC_MCR_LOOP];

    // ==========================================================
    // Modem inputs: pins are active low, status reads their complement
    assign mdm_raw = {~carrier_detect_in_n, ~ring_n_in, ~dsr_n_in, ~cts_n_in}; // [R20]

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            umic_sync u_sync (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .d_in    (mdm_raw[gi]),
                .q_out   (mdm_sync[gi])
            ); // [R24]
        end
    endgenerate

    // Loopback swaps real lines for MODEM_CONTROL: cts<-rts, dsr<-dtr, ri<-aux_user_output_a, dcd<-aux_user_output_b
    wire [3:0] mdm_now = loop ? {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]}
                              : mdm_sync;                      // [R11] [R21]
    wire [3:0] mdm_chg = mdm_now ^ mdm_prev_reg;               // [R12]
    wire [3:0] mdm_evt = {mdm_chg[3], mdm_prev_reg[2] & ~mdm_now[2],
                          mdm_chg[1], mdm_chg[0]};             // [R17] [R18]
    wire       msr_wr  = wr && hit_msr;
    wire       msr_rd  = rd && hit_msr;
    wire       lsr_wr  = wr && hit_lsr;
    wire       lsr_rd  = rd && hit_lsr;

    // Set wins over read clear; test writes may set flags too
    always_comb begin
        msr_flags_next = msr_rd ? 4'h0 : msr_flags_reg;        // [R16]
        if (msr_wr) begin
            msr_flags_next = msr_flags_next | pwdata[3:0];     // [R13]
        end
        msr_flags_next = msr_flags_next | mdm_evt;
    end

    // Line status: errors clear on read, bit 0 and 5 mirror inputs
    always_comb begin
        lsr_next = lsr_reg;
        lsr_next[0] = rx_data_ready;
        lsr_next[5] = tx_holding_empty;
        if (lsr_rd) begin
            lsr_next[4:1] = 4'h0;
        end
        if (lsr_wr) begin
            lsr_next = lsr_next | pwdata[5:0];                 // [R13]
        end
        lsr_next[4:1] = lsr_next[4:1] | line_err_set;          // [R23]
    end

    // ==========================================================
    // Interrupt sources, each gated by its enable
    wire rxd_src  = lsr_reg[0];
    wire tx_holding_empty_src = lsr_reg[5];
    wire line_src = |lsr_reg[4:1];                             // [R23]
    wire mdm_src  = |msr_flags_reg;                            // [R19]
    wire rxd_req  = rxd_src  & ier_reg[0];                     // [R1]
    wire tx_holding_empty_req = tx_holding_empty_src & ier_reg[1];                     // [R2]
    wire line_req = line_src & ier_reg[2];                     // [R3]
    wire mdm_req  = mdm_src  & ier_reg[3];                     // [R4]
    wire any_req  = rxd_req | tx_holding_empty_req | line_req | mdm_req;   // [R6]
    logic [2:0] id_code;

    umic_prio u_prio (
        .line_req (line_req),
        .rxd_req  (rxd_req),
        .tx_holding_empty_req (tx_holding_empty_req),
        .mdm_req  (mdm_req),
        .id_code  (id_code)
    ); // [R22]

    // Read data select; upper bits of INTERRUPT_ENABLE and MODEM_CONTROL read zero
    wire [7:0] rd_byte = hit_ier ? {4'h0, ier_reg}                          // [R5]
                       : hit_mcr ? {3'h0, mcr_reg}                          // [R15]
                       : hit_msr ? {mdm_now, msr_flags_reg}
                       : hit_lsr ? {2'b00, lsr_reg}
                       : hit_iir ? {5'h00, iir_reg} : 8'h00;

    // ==========================================================
    // Control registers, cleared at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ier_reg <= UMIC_IER_RST[3:0];                      // [R25]
            mcr_reg <= UMIC_MCR_RST[4:0];                      // [R25]
        end else if (wr) begin
            if (hit_ier) ier_reg <= pwdata[3:0] & UMIC_IER_MASK;
            if (hit_mcr) mcr_reg <= pwdata[4:0] & UMIC_MCR_MASK; // [R14]
        end
    end

    // Status registers and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msr_flags_reg <= 4'h0;
            mdm_prev_reg  <= 4'h0;
            lsr_reg       <= UMIC_LSR_RST[5:0];
            prime_reg     <= 1'b0;
        end else if (ce) begin
            prime_reg     <= 1'b1;
            mdm_prev_reg  <= mdm_now;
            msr_flags_reg <= prime_reg ? msr_flags_next : 4'h0;
            lsr_reg       <= lsr_next;
        end
    end

    // Identification and irq; inhibited when nothing enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iir_reg <= UMIC_ID_NONE;
            irq_out <= 1'b0;
        end else if (ce) begin
            iir_reg <= (ier_reg == 4'h0) ? UMIC_ID_NONE : id_code; // [R6]
            irq_out <= any_req;                                    // [R6]
        end
    end

    // Modem control pins, inverted; serial path with loopback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_ready_n        <= 1'b1;
            req_to_send_n       <= 1'b1;
            aux_user_output_a_n <= 1'b1;
            aux_user_output_b_n <= 1'b1;
            serial_tx_pin       <= 1'b1;
            rx_shift_in         <= 1'b1;
        end else if (ce) begin
            term_ready_n        <= ~mcr_reg[0];                          // [R7]
            req_to_send_n       <= ~mcr_reg[1];                          // [R8]
            aux_user_output_a_n <= ~mcr_reg[2];                          // [R9]
            aux_user_output_b_n <= ~mcr_reg[3];                          // [R9]
            serial_tx_pin       <= loop ? 1'b1 : tx_shift_out;           // [R10]
            rx_shift_in         <= loop ? tx_shift_out : serial_rx_pin;  // [R10]
        end
    end

    // APB answer, zero wait states; unmapped gives slverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= {24'h00_0000, rd_byte};
        end
    end

    // ==========================================================
    // Checks, all on the bus clock and held off during reset
    default clocking chk_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Setup cycle seen by the slave
    sequence apb_setup_s;
        ce && psel && !penable;
    endsequence

    // Access cycle completing with the answer up
    sequence apb_done_s;
        ce && psel && penable && pready;
    endsequence

    // Status read with no fresh modem event in the same cycle
    sequence msr_read_quiet_s;
        msr_rd && mdm_evt == 4'h0;
    endsequence

    // Status read while the loop is closed
    sequence msr_read_loop_s;
        msr_rd && loop;
    endsequence

    // Bus answer: zero wait states, ready lasts one access only
    apb_ready_a: assert property (
        apb_setup_s |=> pready)
        else $error("pready missing after setup");
    apb_pulse_a: assert property (
        apb_setup_s ##1 apb_done_s |=> !pready)
        else $error("pready held beyond one access");

    // Interrupt gating, each source by its own enable
    ier_gate_a: assert property ( // [R6]
        ce && ier_reg == 4'h0 |=> !irq_out)
        else $error("irq with all enables off");
    rxd_irq_a: assert property ( // [R1]
        ce && rxd_req |=> irq_out)
        else $error("enabled data source gave no irq");
    tx_holding_empty_irq_a: assert property ( // [R2]
        ce && tx_holding_empty_req |=> irq_out)
        else $error("enabled empty source gave no irq");
    line_irq_a: assert property ( // [R3]
        ce && line_req |=> irq_out)
        else $error("enabled line source gave no irq");
    mdm_irq_a: assert property ( // [R4] [R19]
        ce && ier_reg[3] && msr_flags_reg != 4'h0 |=> irq_out)
        else $error("enabled modem source gave no irq");
    line_prio_a: assert property ( // [R22]
        ce && line_req |=> iir_reg == UMIC_ID_LINE)
        else $error("line status not top priority");
    data_prio_a: assert property ( // [R22]
        ce && rxd_req && !line_req |=> iir_reg == UMIC_ID_RXD)
        else $error("data not second priority");

    // Read-back of fixed zero bits
    ier_zero_a: assert property ( // [R5]
        rd && hit_ier |=> prdata[7:4] == 4'h0)
        else $error("ier upper bits nonzero");
    mcr_zero_a: assert property ( // [R15]
        rd && hit_mcr |=> prdata[7:5] == 3'h0)
        else $error("mcr upper bits nonzero");

    // Modem control pins follow the stored bits, inverted
    dtr_pin_a: assert property ( // [R7]
        ce && $past(ce) |-> term_ready_n == ~$past(mcr_reg[0]))
        else $error("terminal ready polarity");
    rts_pin_a: assert property ( // [R8]
        ce && $past(ce) |-> req_to_send_n == ~$past(mcr_reg[1]))
        else $error("request to send polarity");
    aux_a_pin_a: assert property ( // [R9]
        ce && $past(ce) |-> aux_user_output_a_n == ~$past(mcr_reg[2]))
        else $error("aux output a polarity");
    aux_b_pin_a: assert property ( // [R9]
        ce && $past(ce) |-> aux_user_output_b_n == ~$past(mcr_reg[3]))
        else $error("aux output b polarity");

    // Serial path in and out of the loop
    loop_mark_a: assert property ( // [R10]
        ce && loop |=> serial_tx_pin)
        else $error("tx not marking in loop");
    loop_rx_a: assert property ( // [R10]
        ce && loop |=> rx_shift_in == $past(tx_shift_out))
        else $error("receiver not fed from transmitter");
    norm_tx_a: assert property ( // [R10]
        ce && !loop |=> serial_tx_pin == $past(tx_shift_out))
        else $error("tx pin not following shifter");
    loop_msr_a: assert property ( // [R21] [R11]
        msr_read_loop_s |=> prdata[7:4] == {$past(mcr_reg[3]), $past(mcr_reg[2]),
                                            $past(mcr_reg[0]), $past(mcr_reg[1])})
        else $error("loop status not mirroring control");

    // Change flags: set on events and test writes, cleared by a read
    msr_clear_a: assert property ( // [R16]
        msr_read_quiet_s |=> msr_flags_reg == 4'h0)
        else $error("flags survived read");
    cts_change_a: assert property ( // [R17]
        ce && prime_reg && mdm_now[0] != mdm_prev_reg[0] |=> msr_flags_reg[0])
        else $error("cts change missed");
    ring_edge_a: assert property ( // [R18]
        ce && prime_reg && mdm_prev_reg[2] && !mdm_now[2] |=> msr_flags_reg[2])
        else $error("ring trailing edge missed");
    ring_lead_a: assert property ( // [R18]
        ce && prime_reg && !mdm_prev_reg[2] && mdm_now[2] && !msr_wr
        && !msr_flags_reg[2] |=> !msr_flags_reg[2])
        else $error("ring leading edge flagged");
    msr_set_a: assert property ( // [R13]
        ce && prime_reg && msr_wr
        |=> (msr_flags_reg & $past(pwdata[3:0])) == $past(pwdata[3:0]))
        else $error("written modem flag not set");
    lsr_err_a: assert property ( // [R23]
        ce && line_err_set != 4'h0
        |=> (lsr_reg[4:1] & $past(line_err_set)) == $past(line_err_set))
        else $error("line error not latched");
endmodule // umic_ctrl

// [src/umic_pkg.sv]
package umic_pkg;

    // ==========================================================
    // Register byte offsets on the APB
    localparam logic [7:0] UMIC_OFF_IER  = 8'h04;
    localparam logic [7:0] UMIC_OFF_IIR  = 8'h08;
    localparam logic [7:0] UMIC_OFF_LSR  = 8'h14;
    localparam logic [7:0] UMIC_OFF_MCR  = 8'h10;
    localparam logic [7:0] UMIC_OFF_MSR  = 8'h18;

    // ==========================================================
    // Reset values and field masks
    localparam logic [7:0] UMIC_IER_RST  = 8'h00;
    localparam logic [7:0] UMIC_MCR_RST  = 8'h00;
    localparam logic [7:0] UMIC_LSR_RST  = 8'h60;
    localparam logic [3:0] UMIC_IER_MASK = 4'hF;
    localparam logic [4:0] UMIC_MCR_MASK = 5'h1F;
    localparam int         UMIC_MCR_LOOP = 4;

    // Interrupt identification codes, bits 2:0
    localparam logic [2:0] UMIC_ID_NONE  = 3'h1;
    localparam logic [2:0] UMIC_ID_LINE  = 3'h6;
    localparam logic [2:0] UMIC_ID_RXD   = 3'h4;
    localparam logic [2:0] UMIC_ID_TX_HOLDING_EMPTY  = 3'h2;
    localparam logic [2:0] UMIC_ID_MDM   = 3'h0;

    // Synchroniser depth
    localparam int         UMIC_SYNC_STAGES = 2;

endpackage : umic_pkg

// [src/umic_prio.sv]
`timescale 1ns/1ps
// ==========================================================
// Fixed-priority encoder for the four interrupt sources
module umic_prio
    import umic_pkg::*;
(
    input  wire logic       line_req,
    input  wire logic       rxd_req,
    input  wire logic       tx_holding_empty_req,
    input  wire logic       mdm_req,
    output logic      [2:0] id_code
);
    // Line status first, modem status last
    assign id_code = line_req ? UMIC_ID_LINE :
                     rxd_req  ? UMIC_ID_RXD  :
                     tx_holding_empty_req ? UMIC_ID_TX_HOLDING_EMPTY :
                     mdm_req  ? UMIC_ID_MDM  : UMIC_ID_NONE;
endmodule // umic_prio

// [src/umic_sync.sv]
`timescale 1ns/1ps
// ==========================================================
// Two-flop synchroniser for one modem input
module umic_sync
    import umic_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic d_in,
    output logic      q_out
);
    logic meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            q_out    <= 1'b0;
        end else if (ce) begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule // umic_sync

// [verification/uart_modem_irq_control_tb_top.sv]
`timescale 1ns/1ps
module uart_modem_irq_control_tb_top;
    import umic_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic        tx_shift_out = 0, rx_data_ready = 0, tx_holding_empty = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0]  line_err_set = 0, line_cmd = 4'hF, lv;
    logic        pready, pslverr, cts_n_in, dsr_n_in, ring_n_in, carrier_detect_in_n;
    logic        serial_rx_pin, rx_shift_in, serial_tx_pin, irq_out;
    logic        term_ready_n, req_to_send_n, aux_user_output_a_n, aux_user_output_b_n;
    int          miscompares = 0, comparisons = 0;

    always #4 pclk = ~pclk;

    umic_ctrl u_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cts_n_in, .dsr_n_in, .ring_n_in,
        .carrier_detect_in_n, .serial_rx_pin, .tx_shift_out, .rx_data_ready,
        .tx_holding_empty, .line_err_set, .rx_shift_in, .serial_tx_pin, .term_ready_n,
        .req_to_send_n, .aux_user_output_a_n, .aux_user_output_b_n, .irq_out);

    umic_modem_model u_modem (.pclk, .presetn, .line_cmd, .cts_n_in, .dsr_n_in,
        .ring_n_in, .carrier_detect_in_n, .serial_rx_pin);

    // ==========================================================
    // Shared tasks
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // Request held until the edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        check(what, {24'h0, e}, rd);
    endtask

    task automatic irq_is(input logic e);
        check("irq_out", {31'h0, e}, {31'h0, irq_out});
    endtask

    task automatic pins(input logic [3:0] e);
        check("modem pins", {28'h0, e}, {28'h0, aux_user_output_b_n, aux_user_output_a_n,
            req_to_send_n, term_ready_n});
    endtask

    // Source i alone: blocked with enables clear, passed with its enable set
    task automatic gate(input int i, input logic [2:0] id);
        wr(UMIC_OFF_IER, 8'h00);
        settle(3);
        irq_is(1'b0);
        rdchk("iir gated", UMIC_OFF_IIR, {5'h0, UMIC_ID_NONE});
        wr(UMIC_OFF_IER, 8'h01 << i);
        settle(3);
        irq_is(1'b1);
        rdchk("iir source", UMIC_OFF_IIR, {5'h0, id});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rdchk("ier reset", UMIC_OFF_IER, 8'h00);
        rdchk("mcr reset", UMIC_OFF_MCR, 8'h00);
        pins(4'hF);
        wr(UMIC_OFF_IER, 8'hFF);
        rdchk("ier upper", UMIC_OFF_IER, 8'h0F);
        wr(UMIC_OFF_IER, 8'h00);
        wr(UMIC_OFF_MCR, 8'hE5);
        rdchk("mcr upper", UMIC_OFF_MCR, 8'h05);
        pins(4'hA);
        wr(UMIC_OFF_MCR, 8'h0A);
        settle(2);
        pins(4'h5);
        wr(UMIC_OFF_MCR, 8'h00);
        $display("test regs finished");
    endtask

    task automatic t_irq();
        @(posedge pclk);
        rx_data_ready <= 1'b1;
        gate(0, UMIC_ID_RXD);
        rx_data_ready <= 1'b0;
        tx_holding_empty <= 1'b1;
        gate(1, UMIC_ID_TX_HOLDING_EMPTY);
        tx_holding_empty <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            line_err_set <= 4'h1 << k;
            @(posedge pclk);
            line_err_set <= 4'h0;
            gate(2, UMIC_ID_LINE);
            apb(1'b0, UMIC_OFF_LSR, 32'h0);
            check("lsr error", {27'h0, 4'h1 << k, 1'b0}, rd & 32'h0000_001E);
            settle(2);
            irq_is(1'b0);
        end
        wr(UMIC_OFF_IER, 8'h00);
        $display("test irq finished");
    endtask

    task automatic t_prio();
        @(posedge pclk);
        rx_data_ready <= 1'b1;
        tx_holding_empty <= 1'b1;
        wr(UMIC_OFF_MSR, 8'h01);
        wr(UMIC_OFF_LSR, 8'h02);
        wr(UMIC_OFF_IER, 8'h0F);
        rdchk("iir line", UMIC_OFF_IIR, {5'h0, UMIC_ID_LINE});
        apb(1'b0, UMIC_OFF_LSR, 32'h0);
        rdchk("iir data", UMIC_OFF_IIR, {5'h0, UMIC_ID_RXD});
        rx_data_ready <= 1'b0;
        settle(2);
        rdchk("iir tx_holding_empty", UMIC_OFF_IIR, {5'h0, UMIC_ID_TX_HOLDING_EMPTY});
        tx_holding_empty <= 1'b0;
        settle(2);
        rdchk("iir modem", UMIC_OFF_IIR, {5'h0, UMIC_ID_MDM});
        rdchk("msr written", UMIC_OFF_MSR, 8'h01);
        rdchk("iir none", UMIC_OFF_IIR, {5'h0, UMIC_ID_NONE});
        wr(UMIC_OFF_IER, 8'h00);
        $display("test prio finished");
    endtask

    // Each line driven active in turn, then released; ring flags only on release
    task automatic t_modem();
        lv = 4'hF;
        for (int k = 0; k < 4; k++) begin
            lv[k] = 1'b0;
            line_cmd <= lv;
            settle(6);
            irq_is(1'b0);
            rdchk("msr active", UMIC_OFF_MSR, {~lv, (k == 2) ? 4'h0 : 4'h1 << k});
        end
        wr(UMIC_OFF_IER, 8'h08);
        for (int k = 0; k < 4; k++) begin
            lv[k] = 1'b1;
            line_cmd <= lv;
            settle(6);
            irq_is(1'b1);
            rdchk("msr release", UMIC_OFF_MSR, {~lv, 4'h1 << k});
            settle(2);
            irq_is(1'b0);
        end
        wr(UMIC_OFF_IER, 8'h00);
        $display("test modem finished");
    endtask

    task automatic t_loop();
        wr(UMIC_OFF_MCR, 8'h10);
        line_cmd <= 4'h0;
        settle(6);
        check("tx pin mark", 32'h1, {31'h0, serial_tx_pin});
        rdchk("msr isolated", UMIC_OFF_MSR, 8'h00);
        for (int b = 1; b >= 0; b--) begin
            tx_shift_out <= b[0];
            settle(2);
            check("rx loop", {31'h0, b[0]}, {31'h0, rx_shift_in});
        end
        wr(UMIC_OFF_IER, 8'h08);
        wr(UMIC_OFF_MCR, 8'h12);
        settle(6);
        irq_is(1'b1);
        rdchk("msr loop rts", UMIC_OFF_MSR, 8'h11);
        wr(UMIC_OFF_MCR, 8'h1F);
        settle(6);
        rdchk("msr loop all", UMIC_OFF_MSR, 8'hFA);
        wr(UMIC_OFF_MCR, 8'h10);
        settle(6);
        rdchk("msr loop off", UMIC_OFF_MSR, 8'h0F);
        wr(UMIC_OFF_IER, 8'h00);
        wr(UMIC_OFF_MCR, 8'h00);
        line_cmd <= 4'hF;
        settle(6);
        check("tx pin normal", 32'h0, {31'h0, serial_tx_pin});
        apb(1'b0, UMIC_OFF_MSR, 32'h0);
        $display("test loop finished");
    endtask

    task automatic t_unmapped();
        apb(1'b1, 8'h1C, 32'h0000_00FF);
        check("slverr write", 32'h1, {31'h0, err});
        apb(1'b0, 8'h1C, 32'h0);
        check("slverr read", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        $display("test unmapped finished");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_irq();
        t_prio();
        t_modem();
        t_loop();
        t_unmapped();
        print_verdict();
    end
endmodule // uart_modem_irq_control_tb_top

// [verification/umic_modem_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Modem side: four status lines and the receive data line
module umic_modem_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] line_cmd,
    output logic            cts_n_in,
    output logic            dsr_n_in,
    output logic            ring_n_in,
    output logic            carrier_detect_in_n,
    output logic            serial_rx_pin
);
    // Lines idle inactive; data line churns so a stale bit never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {carrier_detect_in_n, ring_n_in, dsr_n_in, cts_n_in} <= 4'hF;
            serial_rx_pin <= 1'b1;
        end else begin
            {carrier_detect_in_n, ring_n_in, dsr_n_in, cts_n_in} <= line_cmd;
            serial_rx_pin <= ~serial_rx_pin;
        end
    end
endmodule // umic_modem_model
